// ### rtl/sgfc_ctrl.sv
// Global forwarding, self-filter, rate limit and tag insertion control registers
`timescale 1ns/10ps
`default_nettype none
`include "sgfc_consts.svh"
module sgfc_ctrl #(
  parameter int unsigned P_CYC_16MS  = `SGFC_RL_PERIOD_16_MS * `SGFC_CLK_FREQ_KHZ,
  parameter int unsigned P_CYC_64MS  = `SGFC_RL_PERIOD_64_MS * `SGFC_CLK_FREQ_KHZ,
  parameter int unsigned P_CYC_256MS = `SGFC_RL_PERIOD_256_MS * `SGFC_CLK_FREQ_KHZ
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Management register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             reg_hit_o,
  // Unknown VLAN ID forwarding
  output logic             unk_vlan_fwd_o,
  output logic             unk_vlan_drop_o,
  output logic [3:0]       unk_vlan_mask_o,
  // Unknown IP multicast forwarding
  output logic             unk_ipmc_fwd_o,
  output logic             unk_ipmc_drop_o,
  output logic [3:0]       unk_ipmc_mask_o,
  // Egress self-address filter
  input  wire logic [47:0] self_mac_i,
  input  wire logic        egr_valid_i,
  input  wire logic [47:0] egr_sa_i,
  output logic             egr_self_valid_o,
  output logic             egr_self_drop_o,
  // Rate limit and tag insertion controls
  output logic [1:0]       ing_rl_period_o,
  output logic             ing_rl_tick_o,
  output logic             egr_rl_queue_mode_o,
  output logic             pvid_src_sel_o
);

  logic                 rst_sync1_r;
  logic                 rst_sync2_r;
  logic                 rst_n;
  logic                 wr_vlan;
  logic                 wr_self;
  logic                 wr_rl;
  logic [25:0]          per_lim;
  sgfc_pkg::sgfc_state_t st_r;
  sgfc_pkg::sgfc_state_t st_nxt;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_n = rst_sync2_r;

  // Address decode of the three registers
  assign wr_vlan   = reg_wr_i && (reg_addr_i == `SGFC_ADDR_UNK_VLAN);
  assign wr_self   = reg_wr_i && (reg_addr_i == `SGFC_ADDR_SELF_IPMC);
  assign wr_rl     = reg_wr_i && (reg_addr_i == `SGFC_ADDR_RL_TAG);
  assign reg_hit_o = (reg_addr_i == `SGFC_ADDR_UNK_VLAN) || (reg_addr_i == `SGFC_ADDR_SELF_IPMC) ||
                     (reg_addr_i == `SGFC_ADDR_RL_TAG);

  // Last timer count for the selected unit period, its length in cycles minus one
  always_comb begin
    if (st_r.rl_per == `SGFC_RL_PER_16) begin
      per_lim = 26'(P_CYC_16MS - 1);
    end else if (st_r.rl_per == `SGFC_RL_PER_64) begin
      per_lim = 26'(P_CYC_64MS - 1);
    end else begin
      per_lim = 26'(P_CYC_256MS - 1);
    end
  end

  // Next state: register writes, read answer, self filter, period timer
  always_comb begin
    st_nxt = st_r;

    // Writes touch only the writable fields
    if (wr_vlan) begin
      st_nxt.vlan_en  = reg_wdata_i[`SGFC_FWD_EN_BIT];
      st_nxt.vlan_map = reg_wdata_i[`SGFC_MAP_MSB:`SGFC_MAP_LSB];
    end
    if (wr_self) begin
      st_nxt.self_en  = reg_wdata_i[`SGFC_SELF_EN_BIT];
      st_nxt.ipmc_en  = reg_wdata_i[`SGFC_FWD_EN_BIT];
      st_nxt.ipmc_map = reg_wdata_i[`SGFC_MAP_MSB:`SGFC_MAP_LSB];
    end
    if (wr_rl) begin
      st_nxt.rl_per   = reg_wdata_i[`SGFC_RL_PER_MSB:`SGFC_RL_PER_LSB];
      st_nxt.qmode    = reg_wdata_i[`SGFC_QMODE_BIT];
      st_nxt.pvid_sel = reg_wdata_i[`SGFC_PVID_SEL_BIT];
    end

    // Read data captured one cycle after the strobe; reserved bits fixed
    st_nxt.rvalid = reg_rd_i;
    st_nxt.rdata  = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SGFC_ADDR_UNK_VLAN: begin
          st_nxt.rdata = {`SGFC_RSV2_VAL, st_r.vlan_en, st_r.vlan_map};
        end
        `SGFC_ADDR_SELF_IPMC: begin
          st_nxt.rdata = {`SGFC_RSV1_VAL, st_r.self_en, st_r.ipmc_en, st_r.ipmc_map};
        end
        `SGFC_ADDR_RL_TAG: begin
          st_nxt.rdata = {`SGFC_RSV2_VAL, st_r.rl_per, st_r.qmode, st_r.pvid_sel, `SGFC_RSV2_VAL};
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Egress source address against own MAC
    st_nxt.self_valid = egr_valid_i;
    st_nxt.self_drop  = egr_valid_i && st_r.self_en && (egr_sa_i == self_mac_i);

    // Unit period timer, restarted when the period changes
    st_nxt.per_tick = 1'b0;
    if (wr_rl && (reg_wdata_i[`SGFC_RL_PER_MSB:`SGFC_RL_PER_LSB] != st_r.rl_per)) begin
      st_nxt.per_cnt = 26'h0000000;
    end else if (st_r.per_cnt >= per_lim) begin
      st_nxt.per_cnt  = 26'h0000000;
      st_nxt.per_tick = 1'b1;
    end else begin
      st_nxt.per_cnt = st_r.per_cnt + 26'h0000001;
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.vlan_en  <= `SGFC_FWD_EN_RST;
      st_r.vlan_map <= `SGFC_MAP_RST;
      st_r.self_en  <= `SGFC_SELF_EN_RST;
      st_r.ipmc_en  <= `SGFC_FWD_EN_RST;
      st_r.ipmc_map <= `SGFC_MAP_RST;
      st_r.rl_per   <= `SGFC_RL_PER_RST;
      st_r.qmode    <= `SGFC_QMODE_RST;
      st_r.pvid_sel <= `SGFC_PVID_SEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Unknown VLAN ID map decoder
  sgfc_pmap_dec u_vlan_dec (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .en_i    (st_r.vlan_en),
    .map_i   (st_r.vlan_map),
    .fwd_o   (unk_vlan_fwd_o),
    .drop_o  (unk_vlan_drop_o),
    .mask_o  (unk_vlan_mask_o)
  );

  // Unknown IP multicast map decoder
  sgfc_pmap_dec u_ipmc_dec (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .en_i    (st_r.ipmc_en),
    .map_i   (st_r.ipmc_map),
    .fwd_o   (unk_ipmc_fwd_o),
    .drop_o  (unk_ipmc_drop_o),
    .mask_o  (unk_ipmc_mask_o)
  );

  // Outputs from state flops
  assign reg_rdata_o         = st_r.rdata;
  assign reg_rvalid_o        = st_r.rvalid;
  assign egr_self_valid_o    = st_r.self_valid;
  assign egr_self_drop_o     = st_r.self_drop;
  assign ing_rl_period_o     = st_r.rl_per;
  assign ing_rl_tick_o       = st_r.per_tick;
  assign egr_rl_queue_mode_o = st_r.qmode;
  assign pvid_src_sel_o      = st_r.pvid_sel;

endmodule
`default_nettype wire

// ### rtl/sgfc_consts.svh
// Offsets, field positions, reset values and timing figures of the global forwarding controls
`ifndef SGFC_CONSTS_SVH
`define SGFC_CONSTS_SVH

// Register offsets on the management register port
`define SGFC_ADDR_UNK_VLAN      8'h85
`define SGFC_ADDR_SELF_IPMC     8'h86
`define SGFC_ADDR_RL_TAG        8'h87

// Field positions, shared by 0x85 and 0x86
`define SGFC_FWD_EN_BIT         5
`define SGFC_MAP_MSB            4
`define SGFC_MAP_LSB            0
// Field positions in 0x86
`define SGFC_SELF_EN_BIT        6
// Field positions in 0x87
`define SGFC_RL_PER_MSB         5
`define SGFC_RL_PER_LSB         4
`define SGFC_QMODE_BIT          3
`define SGFC_PVID_SEL_BIT       2

// Reset values of the writable fields
`define SGFC_FWD_EN_RST         1'b0
`define SGFC_MAP_RST            5'h00
`define SGFC_SELF_EN_RST        1'b0
`define SGFC_RL_PER_RST         2'h1
`define SGFC_QMODE_RST          1'b0
`define SGFC_PVID_SEL_RST       1'b0

// Reserved field values, read back unchanged
`define SGFC_RSV2_VAL           2'h0
`define SGFC_RSV1_VAL           1'b0

// Rate limit period selector codes
`define SGFC_RL_PER_16          2'h0
`define SGFC_RL_PER_64          2'h1

// Ingress rate limit unit periods, milliseconds, and the clock rate
`define SGFC_RL_PERIOD_16_MS    16
`define SGFC_RL_PERIOD_64_MS    64
`define SGFC_RL_PERIOD_256_MS   256
`define SGFC_CLK_FREQ_KHZ       200000

`endif

// ### rtl/sgfc_pkg.sv
// Types of the global forwarding control block
`default_nettype none
package sgfc_pkg;

  // State of one port map decoder
  typedef struct packed {
    logic       fwd;
    logic       drop;
    logic [3:0] mask;
  } sgfc_dec_state_t;

  // State of the control register bank
  typedef struct packed {
    logic        vlan_en;
    logic [4:0]  vlan_map;
    logic        self_en;
    logic        ipmc_en;
    logic [4:0]  ipmc_map;
    logic [1:0]  rl_per;
    logic        qmode;
    logic        pvid_sel;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        self_drop;
    logic        self_valid;
    logic [25:0] per_cnt;
    logic        per_tick;
  } sgfc_state_t;

endpackage
`default_nettype wire

// ### rtl/sgfc_pmap_dec.sv
// Decoder of a five-bit unknown-packet forwarding port map
`timescale 1ns/10ps
`default_nettype none
module sgfc_pmap_dec (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [4:0] map_i,
  output logic            fwd_o,
  output logic            drop_o,
  output logic [3:0]      mask_o
);

  sgfc_pkg::sgfc_dec_state_t st_r;
  sgfc_pkg::sgfc_dec_state_t st_nxt;

  // Bit 0 ignored; bits 4:1 select ports 4..1; empty map filters
  always_comb begin
    st_nxt      = '0;
    if (en_i) begin
      if (map_i[4:1] == 4'h0) begin
        st_nxt.drop = 1'b1;
      end else begin
        st_nxt.fwd  = 1'b1;
        st_nxt.mask = map_i[4:1];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fwd_o  = st_r.fwd;
  assign drop_o = st_r.drop;
  assign mask_o = st_r.mask;

endmodule
`default_nettype wire

// ### tb/sgfc_ctrl_monitor.sv
// Concurrent checks on the ports of the global forwarding control block
`timescale 1ns/10ps
`default_nettype none
module sgfc_ctrl_monitor #(
  parameter int unsigned P_CYC_16MS  = 16,
  parameter int unsigned P_CYC_64MS  = 64,
  parameter int unsigned P_CYC_256MS = 256
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        reg_hit_o,
  input wire logic        unk_vlan_fwd_o,
  input wire logic        unk_vlan_drop_o,
  input wire logic [3:0]  unk_vlan_mask_o,
  input wire logic        unk_ipmc_fwd_o,
  input wire logic        unk_ipmc_drop_o,
  input wire logic [3:0]  unk_ipmc_mask_o,
  input wire logic [47:0] self_mac_i,
  input wire logic        egr_valid_i,
  input wire logic [47:0] egr_sa_i,
  input wire logic        egr_self_valid_o,
  input wire logic        egr_self_drop_o,
  input wire logic [1:0]  ing_rl_period_o,
  input wire logic        ing_rl_tick_o,
  input wire logic        egr_rl_queue_mode_o,
  input wire logic        pvid_src_sel_o
);
  logic [7:0] vq, iq, rq, exp_rd;
  logic [5:0] vexp, iexp;
  logic       hit_self;
  logic [25:0] gap_cnt;
  logic [25:0] gap_lim;
  logic        per_wr;

  // Shadow copies of the writable fields, reserved bits masked
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vq <= 8'h00;
      iq <= 8'h00;
      rq <= 8'h10;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h85) vq <= reg_wdata_i & 8'h3f;
      if (reg_addr_i == 8'h86) iq <= reg_wdata_i & 8'h7f;
      if (reg_addr_i == 8'h87) rq <= reg_wdata_i & 8'h3c;
    end
  end

  // Expected decoder outputs and read data
  assign vexp = {vq[5] && |vq[4:1], vq[5] && !(|vq[4:1]), vq[5] ? vq[4:1] : 4'h0};
  assign iexp = {iq[5] && |iq[4:1], iq[5] && !(|iq[4:1]), iq[5] ? iq[4:1] : 4'h0};
  assign exp_rd = (reg_addr_i == 8'h85) ? vq : (reg_addr_i == 8'h86) ? iq : (reg_addr_i == 8'h87) ? rq : 8'h00;
  assign hit_self = egr_valid_i && iq[6] && (egr_sa_i == self_mac_i);

  // Cycles since the last period tick, cleared when the period code changes
  assign per_wr  = reg_wr_i && (reg_addr_i == 8'h87) && (reg_wdata_i[5:4] != rq[5:4]);
  assign gap_lim = (rq[5:4] == 2'h0) ? 26'(P_CYC_16MS - 1) : (rq[5:4] == 2'h1) ? 26'(P_CYC_64MS - 1) :
                   26'(P_CYC_256MS - 1);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_cnt <= 26'h0000000;
    end else if (per_wr || ing_rl_tick_o) begin
      gap_cnt <= 26'h0000000;
    end else begin
      gap_cnt <= gap_cnt + 26'h0000001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_read;
    reg_rd_i;
  endsequence
  sequence s_tick_gap;
    ing_rl_tick_o ##1 !ing_rl_tick_o [*8];
  endsequence

  a_read_data: assert property (s_read |=> reg_rvalid_o && reg_rdata_o == $past(exp_rd))
    else $error("read data or valid wrong");
  a_read_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("read port active without a read");
  a_addr_hit: assert property (reg_hit_o == (reg_addr_i inside {8'h85, 8'h86, 8'h87}))
    else $error("address hit wrong");
  a_vlan_map: assert property ({unk_vlan_fwd_o, unk_vlan_drop_o, unk_vlan_mask_o} == $past(vexp))
    else $error("unknown VLAN outputs wrong");
  a_ipmc_map: assert property ({unk_ipmc_fwd_o, unk_ipmc_drop_o, unk_ipmc_mask_o} == $past(iexp))
    else $error("unknown IP multicast outputs wrong");
  a_self_valid: assert property (egr_self_valid_o == $past(egr_valid_i))
    else $error("self filter valid wrong");
  a_self_drop: assert property (egr_self_drop_o == $past(hit_self))
    else $error("self filter drop wrong");
  a_rl_fields: assert property ({ing_rl_period_o, egr_rl_queue_mode_o, pvid_src_sel_o} == rq[5:2])
    else $error("rate limit controls wrong");
  a_tick_early: assert property (ing_rl_tick_o |-> gap_cnt >= gap_lim)
    else $error("period tick early");
  a_tick_late: assert property (gap_cnt <= gap_lim + 26'h0000003)
    else $error("period tick missing");
  a_tick_gap: assert property (ing_rl_tick_o |-> s_tick_gap)
    else $error("period ticks too close");
endmodule

bind sgfc_ctrl sgfc_ctrl_monitor #(.P_CYC_16MS(P_CYC_16MS), .P_CYC_64MS(P_CYC_64MS), .P_CYC_256MS(P_CYC_256MS)) u_mon (.*);
`default_nettype wire

// ### tb/tb_switch_global_forwarding_ctrl.sv
// Self-checking bench of the global forwarding control registers
`timescale 1ns/10ps
`default_nettype none
module tb_switch_global_forwarding_ctrl;
  logic        clk = 1'b0, reset_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ev = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [47:0] mac = 48'h02_0a_0b_0c_0d_0e, sa = 48'h0;
  logic        rv, hit, vf, vd, i_f, i_d, sv, sd, tick, qm, pv;
  logic [3:0]  vm, im;
  logic [1:0]  per;
  logic [4:0]  maps [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h1e, 5'h1f};
  logic [7:0]  v;
  logic        f, en;
  int          num_errors = 0, checks = 0, cycles = 0, n;

  sgfc_ctrl #(.P_CYC_16MS(16), .P_CYC_64MS(64), .P_CYC_256MS(256)) u_dut (
    .clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_wdata_i(wdata),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .reg_hit_o(hit),
    .unk_vlan_fwd_o(vf), .unk_vlan_drop_o(vd), .unk_vlan_mask_o(vm),
    .unk_ipmc_fwd_o(i_f), .unk_ipmc_drop_o(i_d), .unk_ipmc_mask_o(im),
    .self_mac_i(mac), .egr_valid_i(ev), .egr_sa_i(sa), .egr_self_valid_o(sv), .egr_self_drop_o(sd),
    .ing_rl_period_o(per), .ing_rl_tick_o(tick), .egr_rl_queue_mode_o(qm), .pvid_src_sel_o(pv));

  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One write strobe, then wait until decoded outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
    @(negedge clk);
  endtask

  // One read strobe, answer looked at in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk("rvalid", {15'h0, rv}, 16'h1);
    chk("rdata", {8'h0, rdata}, {8'h0, e});
    chk("hit", {15'h0, hit}, {15'h0, (a inside {8'h85, 8'h86, 8'h87})});
  endtask

  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // Reset values, unmapped space, reserved bits
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h10);
    wr(8'h84, 8'hff);
    rd(8'h84, 8'h00);
    rd(8'h88, 8'h00);
    wr(8'h85, 8'hff);
    rd(8'h85, 8'h3f);
    wr(8'h86, 8'hff);
    rd(8'h86, 8'h7f);
    wr(8'h87, 8'hff);
    rd(8'h87, 8'h3c);
    // Port map decode with enable set then clear
    for (int i = 0; i < 16; i++) begin
      en = (i < 8);
      wr(8'h85, {2'h0, en, maps[i % 8]});
      wr(8'h86, {2'h0, en, maps[i % 8]});
      f = en && (maps[i % 8][4:1] != 4'h0);
      v = {2'h0, f, en & ~f, f ? maps[i % 8][4:1] : 4'h0};
      chk("vlan", {10'h0, vf, vd, vm}, {8'h0, v});
      chk("ipmc", {10'h0, i_f, i_d, im}, {8'h0, v});
    end
    // Self filter: enable off/on, address match/miss
    for (int i = 0; i < 4; i++) begin
      wr(8'h86, {1'b0, i[0], 6'h00});
      sa = mac ^ {47'h0, i[1]};
      ev = 1'b1;
      @(negedge clk);
      ev = 1'b0;
      chk("self", {14'h0, sv, sd}, {14'h0, 1'b1, i[0] & ~i[1]});
      @(negedge clk);
      chk("selfidle", {14'h0, sv, sd}, 16'h0);
    end
    // Period codes, egress mode and tag selection
    for (int i = 0; i < 4; i++) begin
      v = {2'h0, i[1:0], i[1], i[0], 2'h0};
      wr(8'h87, v);
      chk("rlctl", {12'h0, per, qm, pv}, {12'h0, v[5:2]});
      n = 0;
      while (tick !== 1'b1 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (tick !== 1'b1 && n < 1000);
      chk("tickgap", n[15:0], (i == 0) ? 16'h10 : (i == 1) ? 16'h40 : 16'h100);
    end
    // Reset in mid-run restores every default
    @(negedge clk);
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h10);
    chk("vlanrst", {10'h0, vf, vd, vm}, 16'h0);
    chk("rlrst", {12'h0, per, qm, pv}, 16'h4);
    close_out();
  end
endmodule
`default_nettype wire
